// *** lrc_pkg.sv ***
// lrc_pkg: constants, field layout and types of the LED current and ramp control block.
// assumes one system clock; the PWM clock arrives as a pin and is sampled, not clocked on.
package lrc_pkg;

  // ----------------------------------------------------------------
  // register addresses (7-bit command address)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_CONFIG     = 7'h10;
  localparam logic [6:0] ADDR_RAMP_DOWN  = 7'h11;
  localparam logic [6:0] ADDR_RAMP_UP    = 7'h12;
  localparam logic [6:0] ADDR_SEL_LOW    = 7'h13;
  localparam logic [6:0] ADDR_SEL_HIGH   = 7'h14;
  localparam logic [6:0] ADDR_FULL_SCALE = 7'h15;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FADE_LSB          = 0;
  localparam int HOLD_LSB          = 3;
  localparam int RAMP_UP_LSB       = 0;
  localparam int CODE_W            = 3;
  localparam int CFG_RUN_BIT       = 0;
  localparam int CFG_CSWAKE_BIT    = 1;
  localparam int CFG_RAMPUP_EN_BIT = 2;
  localparam int CFG_ST_HOLD_BIT   = 3;
  localparam int CFG_ST_FADE_BIT   = 4;
  localparam int CFG_ST_RAMP_BIT   = 5;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int                NUM_PORTS      = 10;
  localparam int                SEL_LOW_PORTS  = 8;
  localparam int                LEVEL_W        = 5;
  localparam logic [2:0]        FULL_SCALE_RST = 3'h7;
  localparam logic [9:0]        SEL_RST        = 10'h000;
  localparam logic [5:0]        RAMP_DOWN_RST  = 6'h00;
  localparam logic [2:0]        RAMP_UP_RST    = 3'h0;
  localparam logic              CSWAKE_RST     = 1'b0;
  localparam logic              RAMPUP_EN_RST  = 1'b0;
  localparam logic [2:0]        DAC_MAX        = 3'h7;
  localparam logic [2:0]        DAC_MIN        = 3'h0;
  localparam int                STEPS_LOG2     = 3;

  // ----------------------------------------------------------------
  // timing: shortest phase (code 1) lasts 1/16 s of the PWM clock
  // ----------------------------------------------------------------
  localparam int PWM_CLK_HZ   = 32768;
  localparam int BASE_TIME_US = 62500;
  localparam int BASE_TICKS   = (BASE_TIME_US * PWM_CLK_HZ) / 1000000;
  localparam int DUR_W        = 18;

  typedef enum logic [2:0] {
    SEQ_RUN,
    SEQ_HOLD,
    SEQ_FADE,
    SEQ_SHUT,
    SEQ_RAMP
  } lrc_seq_t;

endpackage : lrc_pkg

// *** lrc_top.sv ***
// lrc_top: register file, shutdown/wake sequencer and per-port sink level for ten LED ports.
// assumes the serial frame logic on clk_sys hands over decoded register reads and writes,
// and that pwm_clk and cs_n are raw pins from outside this clock domain.
`timescale 1ns/1ps

module lrc_top
  import lrc_pkg::*;
#(
  parameter logic [DUR_W-1:0] BASE_TICKS_P = DUR_W'(BASE_TICKS)
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic [6:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic                         pwm_clk,
  input  wire logic                         cs_n,
  output logic      [NUM_PORTS*LEVEL_W-1:0] port_sink_level,
  output logic      [2:0]                   fade_level,
  output logic                              shutdown_active
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic pwm_meta_reg, pwm_sync_reg, pwm_last_reg;
  logic cs_meta_reg,  cs_sync_reg,  cs_last_reg;
  logic pwm_meta_next, pwm_sync_next, pwm_last_next;
  logic cs_meta_next,  cs_sync_next,  cs_last_next;
  logic pwm_tick;
  logic cs_fall;

  // the meta stage feeds only the sync stage; edges are taken one stage later
  always_comb begin
    pwm_meta_next = pwm_clk;
    pwm_sync_next = pwm_meta_reg;
    pwm_last_next = pwm_sync_reg;
    cs_meta_next  = cs_n;
    cs_sync_next  = cs_meta_reg;
    cs_last_next  = cs_sync_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_meta_reg <= 1'b0;
      pwm_sync_reg <= 1'b0;
      pwm_last_reg <= 1'b0;
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      cs_last_reg  <= 1'b1;
    end else begin
      pwm_meta_reg <= pwm_meta_next;
      pwm_sync_reg <= pwm_sync_next;
      pwm_last_reg <= pwm_last_next;
      cs_meta_reg  <= cs_meta_next;
      cs_sync_reg  <= cs_sync_next;
      cs_last_reg  <= cs_last_next;
    end
  end

  assign pwm_tick = pwm_sync_reg & ~pwm_last_reg;
  assign cs_fall  = ~cs_sync_reg & cs_last_reg;

  // ----------------------------------------------------------------
  // host registers
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] sel_reg,       sel_next;
  logic [2:0]           iset_reg,      iset_next;
  logic [5:0]           ramp_down_reg, ramp_down_next;
  logic [2:0]           ramp_up_reg,   ramp_up_next;
  logic                 cswake_reg,    cswake_next;
  logic                 rampup_en_reg, rampup_en_next;
  logic                 cfg_wr;

  assign cfg_wr = reg_wr && (reg_addr == ADDR_CONFIG);

  // plain stores; the sequencer reads them, the outputs pick them up on a tick
  always_comb begin
    sel_next       = sel_reg;
    iset_next      = iset_reg;
    ramp_down_next = ramp_down_reg;
    ramp_up_next   = ramp_up_reg;
    cswake_next    = cswake_reg;
    rampup_en_next = rampup_en_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SEL_LOW:    sel_next[SEL_LOW_PORTS-1:0] = reg_wdata;
        ADDR_SEL_HIGH:   sel_next[NUM_PORTS-1:SEL_LOW_PORTS] = reg_wdata[1:0];
        ADDR_FULL_SCALE: iset_next = reg_wdata[2:0];
        ADDR_RAMP_DOWN:  ramp_down_next = reg_wdata[5:0];
        ADDR_RAMP_UP:    ramp_up_next = reg_wdata[RAMP_UP_LSB +: CODE_W];
        ADDR_CONFIG: begin
          cswake_next    = reg_wdata[CFG_CSWAKE_BIT];
          rampup_en_next = reg_wdata[CFG_RAMPUP_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_reg       <= SEL_RST;
      iset_reg      <= FULL_SCALE_RST;
      ramp_down_reg <= RAMP_DOWN_RST;
      ramp_up_reg   <= RAMP_UP_RST;
      cswake_reg    <= CSWAKE_RST;
      rampup_en_reg <= RAMPUP_EN_RST;
    end else begin
      sel_reg       <= sel_next;
      iset_reg      <= iset_next;
      ramp_down_reg <= ramp_down_next;
      ramp_up_reg   <= ramp_up_next;
      cswake_reg    <= cswake_next;
      rampup_en_reg <= rampup_en_next;
    end
  end

  // ----------------------------------------------------------------
  // duration helpers
  // ----------------------------------------------------------------
  // code n lasts base << (n-1) ticks; code 0 means the phase is skipped
  function automatic logic [DUR_W-1:0] dur_of(input logic [2:0] code);
    logic [DUR_W-1:0] d;
    d = BASE_TICKS_P << (code - 3'h1);
    return (code == 3'h0) ? '0 : d;
  endfunction : dur_of

  // a fade or ramp has eight dac steps; tiny bases never give a zero step
  function automatic logic [DUR_W-1:0] step_of(input logic [2:0] code);
    logic [DUR_W-1:0] s;
    s = dur_of(code) >> STEPS_LOG2;
    return (s == '0) ? DUR_W'(1) : s;
  endfunction : step_of

  // ----------------------------------------------------------------
  // shutdown / wake sequencer
  // ----------------------------------------------------------------
  lrc_seq_t         state_reg,  state_next;
  logic [DUR_W-1:0] timer_reg,  timer_next;
  logic [DUR_W-1:0] target_reg, target_next;
  logic [2:0]       dac_reg,    dac_next;
  logic [2:0]       hold_code, fade_code;
  logic             timer_done;
  logic             want_shut, want_wake, use_ramp;

  assign hold_code  = ramp_down_reg[HOLD_LSB +: CODE_W];
  assign fade_code  = ramp_down_reg[FADE_LSB +: CODE_W];
  assign timer_done = (timer_reg + DUR_W'(1)) >= target_reg;
  // a single config write with run cleared starts the whole descent
  assign want_shut  = cfg_wr && !reg_wdata[CFG_RUN_BIT] &&
                      (state_reg == SEQ_RUN || state_reg == SEQ_RAMP);
  assign want_wake  = (state_reg == SEQ_SHUT) &&
                      ((cfg_wr && reg_wdata[CFG_RUN_BIT]) || (cs_fall && cswake_reg));
  // the write that wakes the block also chooses whether it ramps
  assign use_ramp   = (cfg_wr ? reg_wdata[CFG_RAMPUP_EN_BIT] : rampup_en_reg) &&
                      (ramp_up_reg != 3'h0);

  always_comb begin
    state_next  = state_reg;
    timer_next  = timer_reg;
    target_next = target_reg;
    dac_next    = dac_reg;
    case (state_reg)
      SEQ_RUN, SEQ_RAMP: begin
        if (want_shut) begin
          timer_next = '0;
          if (hold_code != 3'h0) begin
            state_next  = SEQ_HOLD;
            target_next = dur_of(hold_code);
          end else if (fade_code != 3'h0) begin
            state_next  = SEQ_FADE;
            target_next = step_of(fade_code);
            dac_next    = DAC_MAX;
          end else begin
            state_next = SEQ_SHUT;
            dac_next   = DAC_MIN;
          end
        end else if (state_reg == SEQ_RAMP && pwm_tick) begin
          if (timer_done) begin
            timer_next = '0;
            if (dac_reg == DAC_MAX) begin
              state_next = SEQ_RUN;
            end else begin
              dac_next = dac_reg + 3'h1;
            end
          end else begin
            timer_next = timer_reg + DUR_W'(1);
          end
        end
      end
      SEQ_HOLD: begin
        // outputs keep the dac level they had on entry while the hold-off runs; a cut-short ramp leaves it below full
        if (pwm_tick) begin
          if (timer_done) begin
            timer_next = '0;
            if (fade_code != 3'h0) begin
              state_next  = SEQ_FADE;
              target_next = step_of(fade_code);
              dac_next    = DAC_MAX;
            end else begin
              state_next = SEQ_SHUT;
              dac_next   = DAC_MIN;
            end
          end else begin
            timer_next = timer_reg + DUR_W'(1);
          end
        end
      end
      SEQ_FADE: begin
        if (pwm_tick) begin
          if (timer_done) begin
            timer_next = '0;
            if (dac_reg == DAC_MIN) begin
              state_next = SEQ_SHUT;
            end else begin
              dac_next = dac_reg - 3'h1;
            end
          end else begin
            timer_next = timer_reg + DUR_W'(1);
          end
        end
      end
      SEQ_SHUT: begin
        if (want_wake) begin
          timer_next = '0;
          if (use_ramp) begin
            state_next  = SEQ_RAMP;
            target_next = step_of(ramp_up_reg);
            dac_next    = DAC_MIN;
          end else begin
            state_next = SEQ_RUN;
            dac_next   = DAC_MAX;
          end
        end
      end
      default: begin
        state_next = SEQ_RUN;
        dac_next   = DAC_MAX;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg  <= SEQ_RUN;
      timer_reg  <= '0;
      target_reg <= DUR_W'(1);
      dac_reg    <= DAC_MAX;
    end else begin
      state_reg  <= state_next;
      timer_reg  <= timer_next;
      target_reg <= target_next;
      dac_reg    <= dac_next;
    end
  end

  // ----------------------------------------------------------------
  // per-port sink level and fade level, updated on PWM ticks only; shutdown flag on every cycle
  // ----------------------------------------------------------------
  // the ramp dac sets the master reference, so the full-scale code clips it:
  // a low full scale keeps the current flat until the dac falls below it
  logic [2:0]         eff_code;
  logic [LEVEL_W-1:0] unit_level;
  logic [LEVEL_W-1:0] level_reg  [NUM_PORTS];
  logic [LEVEL_W-1:0] level_next [NUM_PORTS];
  logic [2:0]         fade_reg,  fade_next;
  logic               shut_reg,  shut_next;

  assign eff_code   = (iset_reg < dac_reg) ? iset_reg : dac_reg;
  assign unit_level = LEVEL_W'(eff_code) + LEVEL_W'(1);

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      // level in 1.25mA units: half = unit, full = twice unit
      always_comb begin
        level_next[p] = level_reg[p];
        if (pwm_tick) begin
          if (state_reg == SEQ_SHUT) begin
            level_next[p] = '0;
          end else if (sel_reg[p]) begin
            level_next[p] = unit_level << 1;
          end else begin
            level_next[p] = unit_level;
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          level_reg[p] <= '0;
        end else begin
          level_reg[p] <= level_next[p];
        end
      end

      assign port_sink_level[p*LEVEL_W +: LEVEL_W] = level_reg[p];
    end
  endgenerate

  always_comb begin
    fade_next = pwm_tick ? dac_reg : fade_reg;
    shut_next = (state_reg == SEQ_SHUT);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fade_reg <= DAC_MAX;
      shut_reg <= 1'b0;
    end else begin
      fade_reg <= fade_next;
      shut_reg <= shut_next;
    end
  end

  assign fade_level      = fade_reg;
  assign shutdown_active = shut_reg;

  // ----------------------------------------------------------------
  // read port: one cycle latency, unmapped addresses read zero
  // ----------------------------------------------------------------
  logic [7:0] rdata_reg,  rdata_next;
  logic       rvalid_reg, rvalid_next;

  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SEL_LOW:    rdata_next = sel_reg[SEL_LOW_PORTS-1:0];
        ADDR_SEL_HIGH:   rdata_next = {6'h00, sel_reg[NUM_PORTS-1:SEL_LOW_PORTS]};
        ADDR_FULL_SCALE: rdata_next = {5'h00, iset_reg};
        ADDR_RAMP_DOWN:  rdata_next = {2'h0, ramp_down_reg};
        ADDR_RAMP_UP:    rdata_next = {5'h00, ramp_up_reg};
        ADDR_CONFIG: begin
          rdata_next = 8'h00;
          rdata_next[CFG_RUN_BIT]       = (state_reg == SEQ_RUN) || (state_reg == SEQ_RAMP);
          rdata_next[CFG_CSWAKE_BIT]    = cswake_reg;
          rdata_next[CFG_RAMPUP_EN_BIT] = rampup_en_reg;
          rdata_next[CFG_ST_HOLD_BIT]   = (state_reg == SEQ_HOLD);
          rdata_next[CFG_ST_FADE_BIT]   = (state_reg == SEQ_FADE);
          rdata_next[CFG_ST_RAMP_BIT]   = (state_reg == SEQ_RAMP);
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

endmodule : lrc_top

// *** lrc_props.sv ***
// lrc_props: concurrent checks on the register bus and sequencer outputs of lrc_top.
// assumes one clk_sys domain with synchronous active-high rst; attached by bind below.
`timescale 1ns/1ps

module lrc_props
  import lrc_pkg::*;
#(
  parameter logic [DUR_W-1:0] BASE_TICKS_P = DUR_W'(BASE_TICKS)
) (
  input wire logic                         clk_sys,
  input wire logic                         rst,
  input wire logic [6:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  input wire logic                         reg_rvalid,
  input wire logic                         pwm_clk,
  input wire logic                         cs_n,
  input wire logic [NUM_PORTS*LEVEL_W-1:0] port_sink_level,
  input wire logic [2:0]                   fade_level,
  input wire logic                         shutdown_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // register bus answers
  // ----------------------------------------------------------------
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered in the next cycle");
  a_no_spurious_valid: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without a read");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // reserved bits must read zero whatever was written
  a_high_sel_zero: assert property (
    reg_rd && reg_addr == ADDR_SEL_HIGH |=> reg_rdata[7:2] == 6'h00)
    else $error("upper select bits not zero");
  a_scale_upper_zero: assert property (
    reg_rd && reg_addr == ADDR_FULL_SCALE |=> reg_rdata[7:3] == 5'h00)
    else $error("full scale upper bits not zero");
  a_down_upper_zero: assert property (
    reg_rd && reg_addr == ADDR_RAMP_DOWN |=> reg_rdata[7:6] == 2'h0)
    else $error("ramp down upper bits not zero");
  a_up_upper_zero: assert property (
    reg_rd && reg_addr == ADDR_RAMP_UP |=> reg_rdata[7:3] == 5'h00)
    else $error("ramp up upper bits not zero");
  a_status_onehot: assert property (
    reg_rd && reg_addr == ADDR_CONFIG |=> $onehot0(reg_rdata[5:3]))
    else $error("more than one status bit set");

  // ----------------------------------------------------------------
  // sink levels and wake
  // ----------------------------------------------------------------
  a_level_limit: assert property (
    port_sink_level[4:0] <= 5'h10 && port_sink_level[49:45] <= 5'h10)
    else $error("port level above full scale");
  // a wake write without ramp must leave shutdown at once, not after a ramp
  a_wake_instant: assert property (
    shutdown_active && reg_wr && reg_addr == ADDR_CONFIG && reg_wdata[0] && !reg_wdata[2]
    |-> ##[1:4] !shutdown_active)
    else $error("wake write did not leave shutdown");

  c_hold_seen: cover property (reg_rd && reg_addr == ADDR_CONFIG ##1 reg_rdata[3]);
  c_shut_entry: cover property ($rose(shutdown_active));
  c_shut_exit: cover property ($fell(shutdown_active));
endmodule : lrc_props

bind lrc_top lrc_props #(.BASE_TICKS_P(BASE_TICKS_P)) u_props (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pwm_clk(pwm_clk), .cs_n(cs_n), .port_sink_level(port_sink_level),
  .fade_level(fade_level), .shutdown_active(shutdown_active)
);

// *** lrc_host_pins.sv ***
// lrc_host_pins: far-side model driving the pwm clock pin and chip-select pulses.
// assumes clk_sys at 100 ns; pins change on its falling edge only.
`timescale 1ns/1ps

module lrc_host_pins (
  input  wire logic clk_sys,
  input  wire logic cs_req,
  output logic      pwm_clk,
  output logic      cs_n
);
  logic [2:0] div_reg    = 3'h0;
  logic [3:0] cs_cnt_reg = 4'h0;

  // pwm period of 8 system cycles; it runs free so no sequence is starved
  always_ff @(negedge clk_sys) begin
    div_reg    <= div_reg + 3'h1;
    cs_cnt_reg <= cs_req ? 4'h8 : (cs_cnt_reg != 4'h0 ? cs_cnt_reg - 4'h1 : 4'h0);
  end
  assign pwm_clk = div_reg[2];
  assign cs_n    = (cs_cnt_reg == 4'h0);
endmodule : lrc_host_pins

// *** test_led_current_ramp_control.sv ***
// test_led_current_ramp_control: self-checking bench for lrc_top.
// assumes lrc_host_pins supplies pwm clock and chip select; short base ticks.
`timescale 1ns/1ps

module test_led_current_ramp_control;
  import lrc_pkg::*;

  typedef struct {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } lrc_row_t;

  logic                         clk_sys   = 1'b0;
  logic                         rst       = 1'b1;
  logic [6:0]                   reg_addr  = 7'h00;
  logic [7:0]                   reg_wdata = 8'h00;
  logic                         reg_wr    = 1'b0;
  logic                         reg_rd    = 1'b0;
  logic                         cs_req    = 1'b0;
  logic [7:0]                   reg_rdata;
  logic                         reg_rvalid;
  logic                         pwm_clk;
  logic                         cs_n;
  logic [NUM_PORTS*LEVEL_W-1:0] port_sink_level;
  logic [2:0]                   fade_level;
  logic                         shutdown_active;
  int                           fails        = 0;
  int                           total_checks = 0;
  lrc_row_t                     rows [8];

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  lrc_top #(.BASE_TICKS_P(DUR_W'(8))) uut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pwm_clk(pwm_clk), .cs_n(cs_n), .port_sink_level(port_sink_level),
    .fade_level(fade_level), .shutdown_active(shutdown_active)
  );
  lrc_host_pins host (.clk_sys(clk_sys), .cs_req(cs_req), .pwm_clk(pwm_clk), .cs_n(cs_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  // answer is sampled half a cycle after the strobe was taken
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    chk("rvalid", reg_rvalid, 1'b1);
    chk("rdata", reg_rdata, exp);
    reg_rd = 1'b0;
  endtask : rd

  task automatic ticks(input int n);
    repeat (n * 8) @(negedge clk_sys);
  endtask : ticks

  // bounded wait on the shutdown flag or the ramp dac
  task automatic wait_until(input logic on_dac, input logic [2:0] v);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(negedge clk_sys);
      if (on_dac ? fade_level === v : shutdown_active === v[0]) break;
    end
    if (i == 2000) begin
      fails++;
      $display("[FAIL] wait expected %h seen timeout", v);
      wrap_up();
    end
  endtask : wait_until

  function automatic logic [NUM_PORTS*LEVEL_W-1:0] lvl(input logic [9:0] sel,
                                                       input logic [2:0] code);
    logic [NUM_PORTS*LEVEL_W-1:0] r;
    r = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      r[p*LEVEL_W +: LEVEL_W] = sel[p] ? 5'(2 * (code + 1)) : 5'(code + 1);
    end
    return r;
  endfunction : lvl

  task automatic do_reset;
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    rd(ADDR_FULL_SCALE, 8'h07);
    rd(ADDR_SEL_LOW, 8'h00);
    rd(ADDR_SEL_HIGH, 8'h00);
    rd(ADDR_CONFIG, 8'h01);
    ticks(2);
    chk("reset levels", port_sink_level, lvl(10'h000, 3'h7));
  endtask : do_reset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{ADDR_SEL_LOW, 8'ha5, 8'ha5}, '{ADDR_SEL_HIGH, 8'hff, 8'h03},
             '{ADDR_FULL_SCALE, 8'hfa, 8'h02}, '{ADDR_RAMP_DOWN, 8'hff, 8'h3f},
             '{ADDR_RAMP_UP, 8'hff, 8'h07}, '{7'h20, 8'h55, 8'h00},
             '{ADDR_SEL_LOW, 8'h5a, 8'h5a}, '{ADDR_SEL_HIGH, 8'h02, 8'h02}};
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
    end
    ticks(2);
    chk("levels", port_sink_level, lvl(10'h25a, 3'h2));
    do_reset();
    // hold one base step, fade one base step, ramp up one base step
    wr(ADDR_RAMP_DOWN, 8'h09);
    wr(ADDR_RAMP_UP, 8'h01);
    wr(ADDR_CONFIG, 8'h00);
    rd(ADDR_CONFIG, 8'h08);
    ticks(4);
    chk("hold levels", port_sink_level, lvl(10'h000, 3'h7));
    ticks(6);
    rd(ADDR_CONFIG, 8'h10);
    wait_until(1'b0, 3'h1);
    ticks(2);
    chk("shut levels", port_sink_level, '0);
    wr(ADDR_CONFIG, 8'h05);
    rd(ADDR_CONFIG, 8'h25);
    ticks(12);
    rd(ADDR_CONFIG, 8'h05);
    chk("ramped levels", port_sink_level, lvl(10'h000, 3'h7));
    // zero codes skip both phases; chip-select wake without ramp
    wr(ADDR_RAMP_DOWN, 8'h00);
    wr(ADDR_CONFIG, 8'h02);
    wait_until(1'b0, 3'h1);
    // non-blocking so the partner model sees one clean request cycle at its next edge
    cs_req <= 1'b1;
    @(negedge clk_sys);
    cs_req <= 1'b0;
    wait_until(1'b0, 3'h0);
    ticks(2);
    chk("cs wake dac", fade_level, DAC_MAX);
    wr(ADDR_CONFIG, 8'h00);
    wait_until(1'b0, 3'h1);
    wr(ADDR_CONFIG, 8'h01);
    wait_until(1'b0, 3'h0);
    ticks(2);
    chk("write wake levels", port_sink_level, lvl(10'h000, 3'h7));
    wrap_up();
  end
endmodule : test_led_current_ramp_control
